// ### pkg/ppp_pkg.sv
`default_nettype none
package ppp_pkg;

  // Clock and timing figures; cycle counts round a least time up.
  localparam int CLK_PERIOD_NS = 4;
  localparam int ENTRY_TOGGLES = 6;
  localparam int ENTRY_STABLE_NS = 100;
  localparam int ENTRY_STABLE_CYC = (ENTRY_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TIME_NS = 3700000;
  localparam int PROG_TIME_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_TIME_NS = 7500000;
  localparam int ERASE_TIME_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 21;

  // Action select codes for the load strobe.
  localparam logic [1:0] ACT_ADDR = 2'b00;
  localparam logic [1:0] ACT_DATA = 2'b01;
  localparam logic [1:0] ACT_CMD = 2'b10;

  // Command bytes.
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_FUSE_WR = 8'h40;
  localparam logic [7:0] CMD_LOCK_WR = 8'h20;
  localparam logic [7:0] CMD_FLASH_WR = 8'h10;
  localparam logic [7:0] CMD_EE_WR = 8'h11;
  localparam logic [7:0] CMD_FUSE_RD = 8'h04;
  localparam logic [7:0] CMD_FLASH_RD = 8'h02;
  localparam logic [7:0] CMD_EE_RD = 8'h03;
  localparam logic [7:0] CMD_NOP = 8'h00;

  // Memory geometry.
  localparam int FLASH_AW = 13;
  localparam int FLASH_WORD_BITS = 6;
  localparam int EE_AW = 9;
  localparam int EE_BYTE_BITS = 2;

  // Fuse and lock layout and reset values (1 means unprogrammed).
  localparam logic [7:0] FUSE_LO_RST = 8'h62;
  localparam logic [7:0] FUSE_HI_RST = 8'hff;
  localparam logic [7:0] FUSE_EXT_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam int FUSE_HI_KEEP_EE_BIT = 3;
  localparam int LOCK_LEVEL_A_BIT = 0;
  localparam int LOCK_LEVEL_B_BIT = 1;
  localparam logic [7:0] BOOT_LOCK_MASK = 8'h3c;

  // Pin bundle as seen after synchronisation.
  typedef struct packed {
    logic rst_low;
    logic hv;
    logic load;
    logic act_hi;
    logic act_lo;
    logic bs1;
    logic bs2;
    logic page_latch;
    logic write_n;
    logic oe_n;
    logic [7:0] data;
  } ppp_pins_t;

  typedef enum logic [2:0] {PH_OFF, PH_ARM, PH_FAIL, PH_IDLE, PH_ERASE, PH_PROG_FL,
                            PH_PROG_EE, PH_WAIT} ppp_phase_t;

  typedef struct packed {
    ppp_phase_t phase;
    logic [2:0] toggles;
    logic [4:0] stable;
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ext;
    logic [7:0] lock;
    logic [12:0] walk;
    ppp_pins_t prev;
    logic rdy;
    logic [7:0] dout;
    logic doe;
    logic mode;
  } ppp_state_t;

  // The four entry-select pins as one nibble.
  function automatic logic [3:0] ppp_entry_sel(input ppp_pins_t p);
    return {p.page_latch, p.act_hi, p.act_lo, p.bs1};
  endfunction : ppp_entry_sel

endpackage : ppp_pkg
`default_nettype wire

// ### logic/ppp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_sync #(
  parameter int W = 18
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Asynchronous input and its synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppp_sync_t;

  ppp_sync_t st_r;
  ppp_sync_t st_nxt;

  // The first stage feeds only the second stage.
  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.s2;

endmodule : ppp_sync
`default_nettype wire

// ### logic/ppp_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_timer #(
  parameter int W = 21
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Start pulse with the number of cycles to run.
  input wire logic start,
  input wire logic [W-1:0] cycles,
  // High while counting.
  output logic busy
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
  } ppp_timer_t;

  ppp_timer_t st_r;
  ppp_timer_t st_nxt;

  // A start while running restarts the count; the caller does that only when high voltage drops mid-operation and entry is redone before the count ends.
  always_comb
  begin
    st_nxt = st_r;
    if (start)
    begin
      st_nxt.cnt = cycles - W'(1);
      st_nxt.run = 1'b1;
    end
    else if (st_r.run)
    begin
      if (st_r.cnt == '0)
        st_nxt.run = 1'b0;
      else
        st_nxt.cnt = st_r.cnt - W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign busy = st_r.run;

endmodule : ppp_timer
`default_nettype wire

// ### logic/ppp_port.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_port
  import ppp_pkg::*;
#(
  parameter int PROG_CYC = PROG_TIME_CYC,
  parameter int ERASE_CYC = ERASE_TIME_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Reset pin state as two levels: pulled low, or at programming voltage.
  input wire logic reset_pin_low,
  input wire logic reset_pin_hv,
  // Strobes and selects from the programmer.
  input wire logic load_strobe_pin,
  input wire logic action_select_hi,
  input wire logic action_select_lo,
  input wire logic low_high_byte_select,
  input wire logic second_byte_select,
  input wire logic page_latch_strobe,
  input wire logic write_n,
  input wire logic output_enable_n,
  // Bidirectional data bus split into three signals.
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // Status.
  output logic ready_busy_out,
  output logic prog_mode
);

  ppp_pins_t pins_raw;
  ppp_pins_t p;
  ppp_state_t s_r;
  ppp_state_t s_nxt;
  logic tmr_busy;
  logic tmr_start;
  logic [TIMER_W-1:0] tmr_cycles;

  // Memories and page buffers.
  logic [15:0] flash_mem [0:(1<<FLASH_AW)-1];
  logic [7:0] ee_mem [0:(1<<EE_AW)-1];
  logic [15:0] fl_buf [0:(1<<FLASH_WORD_BITS)-1];
  logic [7:0] ee_buf [0:(1<<EE_BYTE_BITS)-1];

  // Write strobes toward the memories, built in the combinational process.
  logic fl_we;
  logic [FLASH_AW-1:0] fl_waddr;
  logic [15:0] fl_wdata;
  logic ee_we;
  logic [EE_AW-1:0] ee_waddr;
  logic [7:0] ee_wdata;
  logic flb_we;
  logic eeb_we;
  logic buf_clr;

  // Edges and decoded addresses.
  logic load_rise;
  logic latch_rise;
  logic write_fall;
  logic [1:0] act;
  logic in_prog;
  logic keep_ee;
  logic [FLASH_AW-1:0] fl_addr;
  logic [EE_AW-1:0] ee_addr;
  logic [FLASH_AW-1:0] fl_page_base;
  logic [EE_AW-1:0] ee_page_base;

  // Every pin comes from outside the clock domain.
  assign pins_raw = '{rst_low: reset_pin_low, hv: reset_pin_hv, load: load_strobe_pin,
                      act_hi: action_select_hi, act_lo: action_select_lo,
                      bs1: low_high_byte_select, bs2: second_byte_select,
                      page_latch: page_latch_strobe, write_n: write_n,
                      oe_n: output_enable_n, data: data_in};

  ppp_sync #(
    .W($bits(ppp_pins_t))
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d(pins_raw),
    .q(p)
  );

  ppp_timer #(
    .W(TIMER_W)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .start(tmr_start),
    .cycles(tmr_cycles),
    .busy(tmr_busy)
  );

  // Edge detection against the previous synchronised sample.
  assign load_rise = p.load && !s_r.prev.load;
  assign latch_rise = p.page_latch && !s_r.prev.page_latch;
  assign write_fall = !p.write_n && s_r.prev.write_n;
  assign act = {p.act_hi, p.act_lo};
  assign in_prog = (s_r.phase != PH_OFF) && (s_r.phase != PH_ARM) && (s_r.phase != PH_FAIL);
  assign keep_ee = !s_r.fuse_hi[FUSE_HI_KEEP_EE_BIT];

  // Word address: the low bits pick the word, the rest pick the page.
  assign fl_addr = FLASH_AW'({s_r.addr_hi, s_r.addr_lo});
  assign ee_addr = EE_AW'({s_r.addr_hi, s_r.addr_lo});
  assign fl_page_base = {fl_addr[FLASH_AW-1:FLASH_WORD_BITS], FLASH_WORD_BITS'(0)};
  assign ee_page_base = {ee_addr[EE_AW-1:EE_BYTE_BITS], EE_BYTE_BITS'(0)};

  // Main sequencing: entry, loads, operations and the read path.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.prev = p;
    fl_we = 1'b0;
    fl_waddr = '0;
    fl_wdata = 16'hffff;
    ee_we = 1'b0;
    ee_waddr = '0;
    ee_wdata = 8'hff;
    flb_we = 1'b0;
    eeb_we = 1'b0;
    buf_clr = 1'b0;
    tmr_start = 1'b0;
    tmr_cycles = '0;
    unique case (s_r.phase)
      PH_OFF:
      begin
        // Count load strobes while reset is held low, saturating at the needed count.
        if (p.rst_low && load_rise && s_r.toggles != 3'(ENTRY_TOGGLES))
          s_nxt.toggles = s_r.toggles + 3'd1;
        if (p.hv && !s_r.prev.hv)
        begin
          s_nxt.stable = '0;
          if (s_r.toggles == 3'(ENTRY_TOGGLES) && ppp_entry_sel(p) == 4'h0)
            s_nxt.phase = PH_ARM;
          else
            s_nxt.phase = PH_FAIL;
        end
      end
      PH_ARM:
      begin
        // Any movement on the selects inside the window aborts entry.
        if (!p.hv)
          s_nxt.phase = PH_OFF;
        else if (ppp_entry_sel(p) != 4'h0)
          s_nxt.phase = PH_FAIL;
        else if (s_r.stable == 5'(ENTRY_STABLE_CYC - 1))
          s_nxt.phase = PH_IDLE;
        else
          s_nxt.stable = s_r.stable + 5'd1;
      end
      PH_FAIL:
      begin
        // A failed entry stays dead until the high voltage is removed.
        if (!p.hv)
          s_nxt.phase = PH_OFF;
      end
      PH_IDLE:
      begin
        // Loads only happen here, so strobes during an operation are dropped.
        if (load_rise)
        begin
          unique case (act)
            ACT_CMD:
            begin
              if (!p.bs1)
              begin
                s_nxt.cmd = p.data;
                if (p.data == CMD_NOP)
                  buf_clr = 1'b1;
              end
            end
            ACT_ADDR:
            begin
              if (p.bs1)
                s_nxt.addr_hi = p.data;
              else
                s_nxt.addr_lo = p.data;
            end
            ACT_DATA:
            begin
              if (p.bs1)
                s_nxt.data_hi = p.data;
              else
                s_nxt.data_lo = p.data;
            end
            default:
            begin
              s_nxt.cmd = s_r.cmd;
            end
          endcase
        end
        // Page latch fills the buffer slot picked by the current address.
        if (latch_rise)
        begin
          if (s_r.cmd == CMD_FLASH_WR && p.bs1)
            flb_we = 1'b1;
          else if (s_r.cmd == CMD_EE_WR)
            eeb_we = 1'b1;
        end
        // Write pulse starts the operation for the held command.
        if (write_fall)
        begin
          unique case (s_r.cmd)
            CMD_ERASE:
            begin
              s_nxt.phase = PH_ERASE;
              s_nxt.walk = '0;
              tmr_start = 1'b1;
              tmr_cycles = TIMER_W'(ERASE_CYC);
            end
            CMD_FLASH_WR:
            begin
              s_nxt.phase = PH_PROG_FL;
              s_nxt.walk = '0;
              tmr_start = 1'b1;
              tmr_cycles = TIMER_W'(PROG_CYC);
            end
            CMD_EE_WR:
            begin
              if (!p.bs1)
              begin
                s_nxt.phase = PH_PROG_EE;
                s_nxt.walk = '0;
                tmr_start = 1'b1;
                tmr_cycles = TIMER_W'(PROG_CYC);
              end
            end
            CMD_FUSE_WR:
            begin
              // Fuse bytes take the loaded data as is: zero programs, one erases.
              if (!p.bs1 && !p.bs2)
                s_nxt.fuse_lo = s_r.data_lo;
              else if (p.bs1 && !p.bs2)
                s_nxt.fuse_hi = s_r.data_lo;
              else if (!p.bs1 && p.bs2)
                s_nxt.fuse_ext = s_r.data_lo;
              s_nxt.phase = PH_WAIT;
              tmr_start = 1'b1;
              tmr_cycles = TIMER_W'(PROG_CYC);
            end
            CMD_LOCK_WR:
            begin
              // Only clearing is possible; boot locks freeze once both level bits are cleared.
              if (!s_r.lock[LOCK_LEVEL_A_BIT] && !s_r.lock[LOCK_LEVEL_B_BIT])
                s_nxt.lock = s_r.lock & (s_r.data_lo | BOOT_LOCK_MASK);
              else
                s_nxt.lock = s_r.lock & s_r.data_lo;
              s_nxt.phase = PH_WAIT;
              tmr_start = 1'b1;
              tmr_cycles = TIMER_W'(PROG_CYC);
            end
            default:
            begin
              s_nxt.phase = PH_IDLE;
            end
          endcase
        end
      end
      PH_ERASE:
      begin
        // Walk the whole flash; the EEPROM is walked alongside unless kept.
        fl_we = 1'b1;
        fl_waddr = s_r.walk;
        if (!keep_ee && s_r.walk < 13'(1 << EE_AW))
        begin
          ee_we = 1'b1;
          ee_waddr = s_r.walk[EE_AW-1:0];
        end
        if (s_r.walk == '1)
        begin
          s_nxt.lock = LOCK_RST;
          s_nxt.phase = PH_WAIT;
        end
        else
          s_nxt.walk = s_r.walk + 13'd1;
      end
      PH_PROG_FL:
      begin
        // Copy the buffered page into the array one word per cycle.
        fl_we = 1'b1;
        fl_waddr = fl_page_base | FLASH_AW'(s_r.walk[FLASH_WORD_BITS-1:0]);
        fl_wdata = fl_buf[s_r.walk[FLASH_WORD_BITS-1:0]];
        if (s_r.walk[FLASH_WORD_BITS-1:0] == '1)
        begin
          buf_clr = 1'b1;
          s_nxt.phase = PH_WAIT;
        end
        else
          s_nxt.walk = s_r.walk + 13'd1;
      end
      PH_PROG_EE:
      begin
        ee_we = 1'b1;
        ee_waddr = ee_page_base | EE_AW'(s_r.walk[EE_BYTE_BITS-1:0]);
        ee_wdata = ee_buf[s_r.walk[EE_BYTE_BITS-1:0]];
        if (s_r.walk[EE_BYTE_BITS-1:0] == '1)
        begin
          buf_clr = 1'b1;
          s_nxt.phase = PH_WAIT;
        end
        else
          s_nxt.walk = s_r.walk + 13'd1;
      end
      PH_WAIT:
      begin
        // Hold busy for the full self-timed interval.
        if (!tmr_busy)
          s_nxt.phase = PH_IDLE;
      end
    endcase
    // Dropping the high voltage leaves programming mode from any state.
    if (in_prog && !p.hv)
    begin
      s_nxt.phase = PH_OFF;
      s_nxt.toggles = '0;
    end
    // Ready only while a new command can be taken.
    s_nxt.rdy = (s_nxt.phase == PH_IDLE);
    // Mode is registered from the next phase so the pin comes straight from a flop.
    s_nxt.mode = (s_nxt.phase != PH_OFF) && (s_nxt.phase != PH_ARM) && (s_nxt.phase != PH_FAIL);
    // The bus is driven only while output enable is low in programming mode.
    s_nxt.doe = in_prog && !p.oe_n;
    s_nxt.dout = 8'h00;
    unique case (s_r.cmd)
      CMD_FLASH_RD:
        s_nxt.dout = p.bs1 ? flash_mem[fl_addr][15:8] : flash_mem[fl_addr][7:0];
      CMD_EE_RD:
        s_nxt.dout = p.bs1 ? 8'h00 : ee_mem[ee_addr];
      CMD_FUSE_RD:
      begin
        unique case ({p.bs2, p.bs1})
          2'b00: s_nxt.dout = s_r.fuse_lo;
          2'b11: s_nxt.dout = s_r.fuse_hi;
          2'b10: s_nxt.dout = s_r.fuse_ext;
          default: s_nxt.dout = s_r.lock;
        endcase
      end
      default:
        s_nxt.dout = 8'h00;
    endcase
    if (!s_nxt.doe)
      s_nxt.dout = 8'h00;
  end

  // Control state; command and addresses survive every operation.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.phase <= PH_OFF;
      s_r.fuse_lo <= FUSE_LO_RST;
      s_r.fuse_hi <= FUSE_HI_RST;
      s_r.fuse_ext <= FUSE_EXT_RST;
      s_r.lock <= LOCK_RST;
      s_r.prev.write_n <= 1'b1;
      s_r.prev.oe_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Array writes; arrays hold no reset so the contents survive a reset pulse.
  always_ff @(posedge clk)
  begin
    if (fl_we)
      flash_mem[fl_waddr] <= fl_wdata;
    if (ee_we)
      ee_mem[ee_waddr] <= ee_wdata;
  end

  // Page buffers refill with the erased value after each page and on no-op.
  always_ff @(posedge clk)
  begin
    if (reset || buf_clr)
    begin
      for (int i = 0; i < (1 << FLASH_WORD_BITS); i++)
        fl_buf[i] <= 16'hffff;
      for (int j = 0; j < (1 << EE_BYTE_BITS); j++)
        ee_buf[j] <= 8'hff;
    end
    else
    begin
      if (flb_we)
        fl_buf[fl_addr[FLASH_WORD_BITS-1:0]] <= {s_r.data_hi, s_r.data_lo};
      if (eeb_we)
        ee_buf[ee_addr[EE_BYTE_BITS-1:0]] <= s_r.data_lo;
    end
  end

  // Outputs straight from flip-flops.
  assign data_out = s_r.dout;
  assign data_oe = s_r.doe;
  assign ready_busy_out = s_r.rdy;
  assign prog_mode = s_r.mode;

endmodule : ppp_port
`default_nettype wire

// ### tb/ppp_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_port_properties #(
  parameter int PROG_CYC = 200,
  parameter int ERASE_CYC = 9000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Programmer pins.
  input wire logic reset_pin_hv,
  input wire logic action_select_hi,
  input wire logic action_select_lo,
  input wire logic low_high_byte_select,
  input wire logic page_latch_strobe,
  input wire logic write_n,
  input wire logic output_enable_n,
  // Device outputs.
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic ready_busy_out,
  input wire logic prog_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  int unsigned busy_cnt;
  int unsigned wr_age;
  wire logic [3:0] sel = {page_latch_strobe, action_select_hi, action_select_lo,
                          low_high_byte_select};

  // Busy length, and cycles since the write strobe was low; saturating so it never wraps.
  always_ff @(posedge clk)
  begin
    busy_cnt <= (reset || !prog_mode || ready_busy_out) ? 0 : busy_cnt + 1;
    wr_age <= (reset || !write_n) ? 0 : ((wr_age < 100) ? wr_age + 1 : wr_age);
  end

  oe_rise_a: assert property ($rose(data_oe) |-> prog_mode && !$past(output_enable_n, 2))
    else $error("bus driven without a read request");
  oe_fall_a: assert property ($fell(data_oe) && prog_mode |-> $past(output_enable_n, 2))
    else $error("bus released while still requested");
  out_zero_a: assert property (!data_oe |-> data_out == 8'h00)
    else $error("read data shown while not driving");
  ready_mode_a: assert property (ready_busy_out |-> prog_mode)
    else $error("ready outside programming mode");
  busy_max_a: assert property (busy_cnt <= ERASE_CYC + 16)
    else $error("busy lasted too long");
  busy_min_a: assert property ($rose(ready_busy_out) && $past(prog_mode) |-> busy_cnt >= PROG_CYC)
    else $error("operation ended too soon");
  busy_cause_a: assert property ($fell(ready_busy_out) && prog_mode |-> wr_age < 12)
    else $error("busy without a write pulse");
  entry_hv_a: assert property ($rose(prog_mode) |-> reset_pin_hv && $past(reset_pin_hv, 20))
    else $error("entry without held high voltage");
  entry_sel_a: assert property ($rose(prog_mode) |-> $past(sel, 20) == 4'h0)
    else $error("entry with selects moving");
endmodule : ppp_port_properties

bind ppp_port ppp_port_properties #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) u_props (
  .clk(clk), .reset(reset), .reset_pin_hv(reset_pin_hv), .action_select_hi(action_select_hi),
  .action_select_lo(action_select_lo), .low_high_byte_select(low_high_byte_select),
  .page_latch_strobe(page_latch_strobe), .write_n(write_n), .output_enable_n(output_enable_n),
  .data_out(data_out), .data_oe(data_oe), .ready_busy_out(ready_busy_out), .prog_mode(prog_mode)
);
`default_nettype wire

// ### tb/ppp_prog.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_prog
  import ppp_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Pins toward the port.
  output var ppp_pins_t p,
  output logic [7:0] bus_drv
);
  // A released bus shows the inverse of the last byte, so no stale copy can pass.
  assign bus_drv = p.oe_n ? p.data : ~p.data;

  // Strobes idle, both active-low enables high.
  initial p = 18'h00300;

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  // Controls lead each strobe by five cycles as the port sees pins two flops late.
  task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
    {p.act_hi, p.act_lo} = act;
    p.bs1 = bs;
    p.data = d;
    step(5);
    p.load = 1'b1;
    step(6);
    p.load = 1'b0;
    step(6);
  endtask : load

  task automatic cmd(input logic [7:0] c);
    load(ACT_CMD, 1'b0, c);
  endtask : cmd

  task automatic adr(input logic hi, input logic [7:0] d);
    load(ACT_ADDR, hi, d);
  endtask : adr

  task automatic dat(input logic hi, input logic [7:0] d);
    load(ACT_DATA, hi, d);
  endtask : dat

  task automatic latch();
    p.bs1 = 1'b1;
    step(5);
    p.page_latch = 1'b1;
    step(6);
    p.page_latch = 1'b0;
    step(6);
  endtask : latch

  task automatic wr(input logic bs1 = 1'b0, input logic bs2 = 1'b0);
    {p.bs2, p.bs1} = {bs2, bs1};
    step(5);
    p.write_n = 1'b0;
    step(8);
    p.write_n = 1'b1;
    step(4);
  endtask : wr

  task automatic rd(input logic bs1, input logic bs2);
    {p.bs2, p.bs1} = {bs2, bs1};
    step(4);
    p.oe_n = 1'b0;
    step(10);
    p.oe_n = 1'b1;
    step(8);
  endtask : rd

  // Entry; a bad one disturbs a select inside the stable window.
  task automatic enter(input logic bad);
    p.rst_low = 1'b1;
    repeat (6)
    begin
      p.load = 1'b1;
      step(4);
      p.load = 1'b0;
      step(4);
    end
    {p.page_latch, p.act_hi, p.act_lo, p.bs1} = 4'h0;
    step(30);
    p.rst_low = 1'b0;
    p.hv = 1'b1;
    step(6);
    p.bs1 = bad;
    step(4);
    p.bs1 = 1'b0;
  endtask : enter
endmodule : ppp_prog
`default_nettype wire

// ### tb/ppp_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_port_test
  import ppp_pkg::*;
;
  logic clk;
  logic reset = 1'b1;
  ppp_pins_t p;
  logic [7:0] bus_drv;
  logic [7:0] data_out;
  logic data_oe;
  logic ready_busy_out;
  logic prog_mode;
  logic oe_seen = 1'b0;
  int failures = 0;
  int checked = 0;
  logic [7:0] exp_q[$];
  logic [15:0] w[2];
  logic [7:0] e;
  logic [7:0] fv[3];
  logic [7:0] lk[3] = '{8'hfc, 8'h00, 8'hff};

  // 250 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ppp_prog u_prog (.clk(clk), .p(p), .bus_drv(bus_drv));

  ppp_port #(.PROG_CYC(200), .ERASE_CYC(9000)) u_dut (
    .clk(clk), .reset(reset), .reset_pin_low(p.rst_low), .reset_pin_hv(p.hv),
    .load_strobe_pin(p.load), .action_select_hi(p.act_hi), .action_select_lo(p.act_lo),
    .low_high_byte_select(p.bs1), .second_byte_select(p.bs2),
    .page_latch_strobe(p.page_latch), .write_n(p.write_n), .output_enable_n(p.oe_n),
    .data_in(data_oe ? data_out : bus_drv), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_out(ready_busy_out), .prog_mode(prog_mode)
  );

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic stop_test();
    failures += exp_q.size();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic wait_rdy();
    for (int i = 0; i < 12000 && ready_busy_out !== 1'b1; i++)
      @(negedge clk);
    if (ready_busy_out !== 1'b1)
    begin
      failures++;
      stop_test();
    end
  endtask : wait_rdy

  // Write pulse, busy seen at once, then a bounded wait for ready.
  task automatic burn(input logic bs1 = 1'b0, input logic bs2 = 1'b0);
    u_prog.wr(bs1, bs2);
    cmp_bit(ready_busy_out, 1'b0);
    wait_rdy();
  endtask : burn

  task automatic chk(input logic bs1, input logic bs2, input logic [7:0] exp);
    exp_q.push_back(exp);
    u_prog.rd(bs1, bs2);
  endtask : chk

  // Each rise of the drive enable is one read result, settled by the falling edge.
  always @(negedge clk)
  begin
    if (data_oe === 1'b1 && oe_seen !== 1'b1)
      cmp_byte(data_out, (exp_q.size() > 0) ? exp_q.pop_front() : ~data_out);
    oe_seen = data_oe;
  end

  initial
  begin
    void'($urandom(11992));
    repeat (16) @(negedge clk);
    reset = 1'b0;
    cmp_bit(ready_busy_out, 1'b0);
    u_prog.enter(1'b1);
    u_prog.step(60);
    cmp_bit(prog_mode, 1'b0);
    u_prog.p.hv = 1'b0;
    u_prog.step(10);
    u_prog.enter(1'b0);
    wait_rdy();
    cmp_bit(prog_mode, 1'b1);
    u_prog.step(12500);
    // Two words at a page top; an address load while busy must be dropped.
    u_prog.cmd(CMD_FLASH_WR);
    for (int i = 0; i < 2; i++)
    begin
      w[i] = 16'($urandom);
      u_prog.adr(1'b0, 8'h3e + 8'(i));
      u_prog.dat(1'b0, w[i][7:0]);
      u_prog.dat(1'b1, w[i][15:8]);
      u_prog.latch();
    end
    u_prog.adr(1'b1, 8'h05);
    u_prog.wr();
    cmp_bit(ready_busy_out, 1'b0);
    u_prog.adr(1'b0, 8'h00);
    wait_rdy();
    u_prog.cmd(CMD_FLASH_RD);
    chk(1'b0, 1'b0, w[1][7:0]);
    chk(1'b1, 1'b0, w[1][15:8]);
    u_prog.adr(1'b0, 8'h3e);
    chk(1'b0, 1'b0, w[0][7:0]);
    // A no-op must drop a latched word before the next page write.
    u_prog.cmd(CMD_FLASH_WR);
    u_prog.adr(1'b0, 8'h40);
    u_prog.dat(1'b0, 8'h00);
    u_prog.latch();
    u_prog.cmd(CMD_NOP);
    u_prog.cmd(CMD_FLASH_WR);
    burn();
    u_prog.cmd(CMD_FLASH_RD);
    chk(1'b0, 1'b0, 8'hff);
    u_prog.adr(1'b0, 8'h3f);
    chk(1'b1, 1'b0, w[1][15:8]);
    // One EEPROM byte through its page buffer.
    e = 8'($urandom);
    u_prog.cmd(CMD_EE_WR);
    u_prog.adr(1'b1, 8'h01);
    u_prog.adr(1'b0, 8'h06);
    u_prog.dat(1'b0, e);
    u_prog.latch();
    burn();
    u_prog.cmd(CMD_EE_RD);
    chk(1'b0, 1'b0, e);
    // Low, high and extended fuses; high keeps the EEPROM through an erase.
    u_prog.cmd(CMD_FUSE_RD);
    chk(1'b0, 1'b0, FUSE_LO_RST);
    u_prog.cmd(CMD_FUSE_WR);
    for (int i = 0; i < 3; i++)
    begin
      fv[i] = 8'($urandom);
      fv[i][FUSE_HI_KEEP_EE_BIT] = (i != 1);
      u_prog.dat(1'b0, fv[i]);
      burn(i == 1, i == 2);
    end
    u_prog.cmd(CMD_FUSE_RD);
    for (int i = 0; i < 3; i++)
      chk(i == 1, i != 0, fv[i]);
    chk(1'b1, 1'b0, LOCK_RST);
    // Level bits first, then later writes must not touch the boot bits but still clear the rest.
    u_prog.cmd(CMD_LOCK_WR);
    for (int i = 0; i < 3; i++)
    begin
      u_prog.dat(1'b0, lk[i]);
      burn();
    end
    u_prog.cmd(CMD_FUSE_RD);
    chk(1'b1, 1'b0, 8'hfc & BOOT_LOCK_MASK);
    // Erase: flash and locks to ones, fuses and the kept EEPROM untouched.
    u_prog.cmd(CMD_ERASE);
    burn();
    u_prog.cmd(CMD_FUSE_RD);
    chk(1'b1, 1'b0, LOCK_RST);
    chk(1'b1, 1'b1, fv[1]);
    u_prog.cmd(CMD_EE_RD);
    chk(1'b0, 1'b0, e);
    u_prog.cmd(CMD_FLASH_RD);
    u_prog.adr(1'b1, 8'h05);
    chk(1'b1, 1'b0, 8'hff);
    // Releasing the keep fuse lets the next erase wipe the EEPROM as well.
    u_prog.cmd(CMD_FUSE_WR);
    u_prog.dat(1'b0, 8'hff);
    burn(1'b1, 1'b0);
    u_prog.cmd(CMD_ERASE);
    burn();
    u_prog.cmd(CMD_EE_RD);
    chk(1'b0, 1'b0, 8'hff);
    stop_test();
  end
endmodule : ppp_port_test
`default_nettype wire
